// [rsc_checker.sv]
// Port level checks for the reset source combiner
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.vh"
module rsc_checker #(
	parameter [7:0] USER_VEC = 8'h5A
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Bus
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	// Pin and sources
	input wire logic i_rst_pin_n,
	input wire logic o_rst_pin_out,
	input wire logic o_rst_pin_oe,
	input wire logic i_low_supply,
	input wire logic i_fetch,
	input wire logic [15:0] i_fetch_addr,
	input wire logic i_stop_exec,
	input wire logic i_wait_mode,
	// Results
	input wire logic o_int_reset,
	input wire logic o_lp_exit,
	input wire logic o_osc_stop,
	input wire logic o_clk_run
);
	// Non-executable fetch windows
	wire logic ill;
	assign ill = i_fetch_addr <= `RSC_IO_HI
		|| (i_fetch_addr >= `RSC_GAP1_LO && i_fetch_addr <= `RSC_GAP1_HI)
		|| (i_fetch_addr >= `RSC_GAP2_LO && i_fetch_addr <= `RSC_GAP2_HI);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_FETCH: assert property (i_fetch && ill |=> o_int_reset ##1 o_rst_pin_oe)
		else $error("illegal fetch gave no reset");
	AST_PIN_DATA: assert property (o_rst_pin_out == 1'b0)
		else $error("reset pin data not low");
	AST_OE_WIDTH: assert property ($rose(o_rst_pin_oe) |-> o_rst_pin_oe[*3])
		else $error("pulldown shorter than three cycles");
	AST_STOP: assert property (i_stop_exec |=> o_int_reset)
		else $error("disabled stop gave no reset");
	AST_LOW: assert property (i_low_supply |-> ##[1:3] o_int_reset)
		else $error("low supply gave no reset");
	AST_HOLD: assert property ($fell(o_int_reset) |-> !$past(i_low_supply))
		else $error("reset released during low supply");
	AST_ZERO_WAIT: assert property (i_psel && !i_penable |=> o_pready)
		else $error("bus access not answered");
	AST_SVC_READ: assert property (o_pready && !i_pwrite && i_paddr == `RSC_SVC_ADDR
		|-> o_prdata == {24'h000000, USER_VEC})
		else $error("service location read wrong");
	AST_STOP_CLK: assert property (o_osc_stop |-> !o_clk_run)
		else $error("clock runs in stop");
	AST_LP_EXIT: assert property ((o_int_reset && i_wait_mode)[*3] |-> o_lp_exit)
		else $error("reset did not leave wait");
	AST_PIN_SEEN: assert property ($fell(i_rst_pin_n) && !o_rst_pin_oe && !$past(o_rst_pin_oe)
		&& !$past(o_rst_pin_oe, 2) |-> ##[1:5] o_int_reset)
		else $error("pin reset not seen");
	// Main scenarios reached
	COV_FETCH: cover property (i_fetch && ill ##1 o_int_reset);
	COV_STOP: cover property (i_stop_exec ##1 o_int_reset);
	COV_WAIT: cover property (o_lp_exit && i_wait_mode);
endmodule // rsc_checker
`default_nettype wire

// [rsc_delay.v]
// Retriggerable down counter that stays busy for N cycles after its last start
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.vh"

module rsc_delay #(
	parameter W = `RSC_POR_W,
	parameter [W-1:0] N = `RSC_POR_CYCLES
) (
	// Clock and reset
	input wire i_clock,
	input wire i_arst_n,
	// Control
	input wire i_start,
	// Status
	output reg o_busy
);

	localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	reg [W-1:0] cnt_q;

	// Holding start reloads, so the count runs from the start's last cycle
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= {W{1'b0}};
			o_busy <= 1'b0;
		end else if (i_start) begin
			cnt_q <= N;
			o_busy <= 1'b1;
		end else if (cnt_q > ONE) begin
			cnt_q <= cnt_q - ONE;
		end else begin
			cnt_q <= {W{1'b0}};
			o_busy <= 1'b0;
		end
	end

endmodule // rsc_delay

`default_nettype wire

// [rsc_map.vh]
// Address map, field positions and timing counts of the reset source combiner
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// ****************************************************************
// Register addresses (byte addresses on the APB side)
// ****************************************************************
`define RSC_ADDR_W 16
`define RSC_SVC_ADDR 16'h3FF0
`define RSC_CAUSE_ADDR 16'h3FF4

// ****************************************************************
// Field positions
// ****************************************************************
`define RSC_SVC_BIT 0
`define RSC_CAUSE_PIN 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_WDOG 2
`define RSC_CAUSE_LOW 3
`define RSC_CAUSE_ILL 4
`define RSC_CAUSE_STOP 5
`define RSC_CAUSE_W 6

// ****************************************************************
// Reset values
// ****************************************************************
`define RSC_CAUSE_RST 6'h00
`define RSC_USER_VEC 8'h5A

// ****************************************************************
// Timing counts in bus clock cycles
// ****************************************************************
`define RSC_POR_W 12
`define RSC_POR_CYCLES 12'hFE0
`define RSC_PIN_W 3
`define RSC_PIN_CYCLES 3'h4
`define RSC_WDOG_W 18
`define RSC_WDOG_CYCLES 18'h20000

// ****************************************************************
// Fetch address windows that are not executable
// ****************************************************************
`define RSC_IO_HI 16'h003F
`define RSC_GAP1_LO 16'h01C0
`define RSC_GAP1_HI 16'h023F
`define RSC_GAP2_LO 16'h02C0
`define RSC_GAP2_HI 16'h17FF

`endif

// [rsc_pin_model.sv]
// Board side of the open drain reset pin
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_model (
	// Pulldown requests
	input wire logic i_ext_low,
	input wire logic i_oe,
	input wire logic i_out,
	// Wire level
	output logic o_pin_n
);
	// Pull-up wins once nobody pulls down, so a released pin never keeps a stale low
	assign o_pin_n = !(i_ext_low || (i_oe && !i_out));
endmodule // rsc_pin_model
`default_nettype wire

// [rsc_top.v]
// Reset source combiner with watchdog, power-on and low-supply delays
`timescale 1ns/1ns
`default_nettype none
`include "rsc_map.vh"

module rsc_top #(
	parameter WDOG_EN = 1,
	parameter LOW_SUPPLY_EN = 1,
	parameter STOP_DIS = 1,
	parameter [`RSC_POR_W-1:0] POR_CYCLES = `RSC_POR_CYCLES,
	parameter [`RSC_WDOG_W-1:0] WDOG_CYCLES = `RSC_WDOG_CYCLES,
	parameter [7:0] USER_VEC = `RSC_USER_VEC // Arbitrary value
) (
	// Clock and reset
	input wire i_clock,
	input wire i_arst_n,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [`RSC_ADDR_W-1:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Reset pin, open drain
	input wire i_rst_pin_n,
	output reg o_rst_pin_out,
	output reg o_rst_pin_oe,
	// Reset sources
	input wire i_osc_active,
	input wire i_low_supply,
	input wire i_fetch,
	input wire [`RSC_ADDR_W-1:0] i_fetch_addr,
	input wire i_stop_exec,
	input wire i_wait_mode,
	input wire i_irq_wake,
	// Results
	output reg o_int_reset,
	output reg o_mode_load,
	output reg o_lp_exit,
	output reg o_osc_stop,
	output reg o_clk_run
);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	wire apb_setup;
	wire apb_wr;
	wire hit_svc;
	wire hit_cause;
	wire svc_clear;
	wire [`RSC_CAUSE_W-1:0] cause_clr;

	assign apb_setup = i_psel & ~i_penable;
	assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
	assign hit_svc = (i_paddr == `RSC_SVC_ADDR);
	assign hit_cause = (i_paddr == `RSC_CAUSE_ADDR);
	// Only a zero in the service bit counts as a watchdog service
	assign svc_clear = apb_wr & hit_svc & ~i_pwdata[`RSC_SVC_BIT];
	assign cause_clr = (apb_wr & hit_cause) ? i_pwdata[`RSC_CAUSE_W-1:0]
		: {`RSC_CAUSE_W{1'b0}};

	// ****************************************************************
	// Reset pin synchroniser and external reset tracking
	// ****************************************************************
	reg pin_s1_q;
	reg pin_s2_q;
	reg oe_d1_q;
	reg oe_d2_q;
	reg ext_q;
	reg ext_prev_q;
	wire pin_mask;
	wire ext_start;

	// Two flops; the first one feeds nothing but the second
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= i_rst_pin_n;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Our own pulldown echoes back through the synchroniser, so hide it
	assign pin_mask = o_rst_pin_oe | oe_d1_q | oe_d2_q;

	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			oe_d1_q <= 1'b0;
			oe_d2_q <= 1'b0;
			ext_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			oe_d1_q <= o_rst_pin_oe;
			oe_d2_q <= oe_d1_q;
			ext_prev_q <= ext_q;
			if (!pin_mask) begin
				ext_q <= ~pin_s2_q;
			end
		end
	end

	// A pin held low from outside starts one pulse, not a train
	assign ext_start = ext_q & ~ext_prev_q;

	// ****************************************************************
	// Power-on delay
	// ****************************************************************
	reg por_armed_q;
	wire por_start;
	wire por_busy;
	wire por_active;

	// Armed by power-up, fired by the first oscillator activity
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			por_armed_q <= 1'b1;
		end else if (i_osc_active) begin
			por_armed_q <= 1'b0;
		end
	end

	assign por_start = por_armed_q;
	assign por_active = por_armed_q | por_busy;

	rsc_delay #(
		.W(`RSC_POR_W),
		.N(POR_CYCLES)
	) u_por (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_start(por_start),
		.o_busy(por_busy)
	);

	// ****************************************************************
	// Low-supply restart
	// ****************************************************************
	wire low_trip;
	wire low_busy;
	wire low_active;

	// Sensing is not gated by STOP or WAIT; absent when built out
	assign low_trip = (LOW_SUPPLY_EN != 0) & i_low_supply;
	assign low_active = low_trip | low_busy;

	// Held start keeps reloading until supply recovers
	rsc_delay #(
		.W(`RSC_POR_W),
		.N(POR_CYCLES)
	) u_low (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_start(low_trip),
		.o_busy(low_busy)
	);

	// ****************************************************************
	// Event sources: illegal fetch, disabled STOP, watchdog expiry
	// ****************************************************************
	wire ill_evt;
	wire stopdis_evt;
	wire wd_evt;
	wire any_evt;

	assign ill_evt = i_fetch & ((i_fetch_addr <= `RSC_IO_HI)
		| ((i_fetch_addr >= `RSC_GAP1_LO) & (i_fetch_addr <= `RSC_GAP1_HI))
		| ((i_fetch_addr >= `RSC_GAP2_LO) & (i_fetch_addr <= `RSC_GAP2_HI)));
	assign stopdis_evt = i_stop_exec & (STOP_DIS != 0);
	assign any_evt = ill_evt | stopdis_evt | wd_evt;

	// ****************************************************************
	// Pin pulldown pulse and combined reset
	// ****************************************************************
	wire pin_busy;
	wire int_src;
	wire any_rst;

	// Events last one cycle; the pulse stretches them to four
	rsc_delay #(
		.W(`RSC_PIN_W),
		.N(`RSC_PIN_CYCLES)
	) u_pin (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_start(ext_start | any_evt),
		.o_busy(pin_busy)
	);

	assign int_src = por_active | low_active;
	// Reset ends only when every source has gone
	assign any_rst = int_src | ext_q | pin_busy | any_evt;

	// Released on the clock; pulldown as long as an internal source lasts
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_int_reset <= 1'b1;
			o_rst_pin_oe <= 1'b1;
			o_rst_pin_out <= 1'b0;
		end else begin
			o_int_reset <= any_rst;
			o_rst_pin_oe <= pin_busy | int_src;
			o_rst_pin_out <= 1'b0;
		end
	end

	// ****************************************************************
	// Mode reload on the end of a pin or watchdog reset
	// ****************************************************************
	reg mode_src_q;

	// Other sources ending leave the mode selection alone
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_src_q <= 1'b0;
			o_mode_load <= 1'b0;
		end else begin
			o_mode_load <= o_int_reset & ~any_rst & mode_src_q;
			if (ext_q | wd_evt) begin
				mode_src_q <= 1'b1;
			end else if (!any_rst) begin
				mode_src_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// STOP mode and startup delay
	// ****************************************************************
	reg stop_q;
	reg exit_by_rst_q;
	wire stop_exit;
	wire startup_busy;

	assign stop_exit = stop_q & (any_rst | i_irq_wake);

	// A disabled STOP never enters; it resets instead
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stop_q <= 1'b0;
			exit_by_rst_q <= 1'b0;
		end else if (stop_exit) begin
			stop_q <= 1'b0;
			exit_by_rst_q <= any_rst;
		end else if (i_stop_exec && (STOP_DIS == 0) && !any_rst) begin
			stop_q <= 1'b1;
		end
	end

	rsc_delay #(
		.W(`RSC_POR_W),
		.N(POR_CYCLES)
	) u_startup (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_start(stop_exit),
		.o_busy(startup_busy)
	);

	// Low-power exit notice and clock run/stop for the rest of the chip
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_lp_exit <= 1'b0;
			o_osc_stop <= 1'b0;
			o_clk_run <= 1'b0;
		end else begin
			o_lp_exit <= any_rst & (stop_q | i_wait_mode);
			o_osc_stop <= stop_q & ~stop_exit;
			o_clk_run <= ~stop_q & ~startup_busy;
		end
	end

	// ****************************************************************
	// Watchdog counter
	// ****************************************************************
	localparam [`RSC_WDOG_W-1:0] WD_ONE = {{(`RSC_WDOG_W-1){1'b0}}, 1'b1};
	localparam [`RSC_WDOG_W-1:0] WD_LAST = WDOG_CYCLES - WD_ONE;

	reg [`RSC_WDOG_W-1:0] wd_cnt_q;
	wire wd_hold;
	wire wd_clear;

	// Reset exit keeps the counter cleared through the whole startup
	assign wd_hold = startup_busy & exit_by_rst_q;
	assign wd_clear = (WDOG_EN == 0) | o_int_reset | svc_clear | wd_hold
		| (i_stop_exec & ~stop_q & (STOP_DIS == 0));
	assign wd_evt = (WDOG_EN != 0) & ~wd_clear & ~stop_q
		& (wd_cnt_q == WD_LAST);

	// WAIT does not gate the count; an interrupt startup counts too
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wd_cnt_q <= {`RSC_WDOG_W{1'b0}};
		end else if (wd_clear || wd_evt) begin
			wd_cnt_q <= {`RSC_WDOG_W{1'b0}};
		end else if (!stop_q) begin
			wd_cnt_q <= wd_cnt_q + WD_ONE;
		end
	end

	// ****************************************************************
	// Reset cause record, write one to clear
	// ****************************************************************
	reg [`RSC_CAUSE_W-1:0] cause_q;
	wire [`RSC_CAUSE_W-1:0] cause_set;

	assign cause_set = {stopdis_evt, ill_evt, low_trip, wd_evt, por_start, ext_start};

	// A cause arriving with its clear still lands
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cause_q <= `RSC_CAUSE_RST;
		end else begin
			cause_q <= (cause_q & ~cause_clr) | cause_set;
		end
	end

	// ****************************************************************
	// APB answer, zero wait states
	// ****************************************************************
	// Answer is prepared in setup so every output stays a flop
	always @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end else begin
			o_pready <= apb_setup;
			o_pslverr <= apb_setup & ~hit_svc & ~hit_cause;
			if (apb_setup && !i_pwrite && hit_svc) begin
				o_prdata <= {24'h000000, USER_VEC};
			end else if (apb_setup && !i_pwrite && hit_cause) begin
				o_prdata <= {{(32-`RSC_CAUSE_W){1'b0}}, cause_q};
			end else if (apb_setup) begin
				o_prdata <= 32'h00000000;
			end
		end
	end

endmodule // rsc_top

`default_nettype wire

// [rsc_top_tb.sv]
// Self-checking bench for the reset source combiner
`timescale 1ns/1ns
`default_nettype none
module rsc_top_tb;
	localparam int POR = 20;
	// Watchdog period long enough to span a scenario between services
	localparam int WDOG = 128;
	logic i_clock = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [15:0] i_paddr = 16'h0000, i_fetch_addr = 16'h0000;
	logic [31:0] i_pwdata = 32'h00000000, o_prdata, rd;
	logic o_pready, o_pslverr, pin_n, o_rst_pin_out, o_rst_pin_oe, o_int_reset, o_mode_load;
	logic o_lp_exit, o_osc_stop, o_clk_run, err, ext_low = 1'b0, i_osc_active = 1'b0;
	logic i_low_supply = 1'b0, i_fetch = 1'b0, i_stop_exec = 1'b0, i_wait_mode = 1'b0;
	int errors = 0, samples_checked = 0, oe_run = 0, last_oe = 0, ml = 0, lp = 0, c;
	always #2 i_clock = ~i_clock;
	// Watchdog on with STOP turned into a reset, as recommended
	rsc_top #(.WDOG_EN(1), .STOP_DIS(1), .POR_CYCLES(12'h014), .WDOG_CYCLES(18'h00080))
	i_rsc_top (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_rst_pin_n(pin_n),
		.o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe), .i_osc_active(i_osc_active),
		.i_low_supply(i_low_supply), .i_fetch(i_fetch), .i_fetch_addr(i_fetch_addr),
		.i_stop_exec(i_stop_exec), .i_wait_mode(i_wait_mode), .i_irq_wake(1'b0),
		.o_int_reset(o_int_reset), .o_mode_load(o_mode_load), .o_lp_exit(o_lp_exit),
		.o_osc_stop(o_osc_stop), .o_clk_run(o_clk_run));
	rsc_pin_model i_rsc_pin_model (.i_ext_low(ext_low), .i_oe(o_rst_pin_oe),
		.i_out(o_rst_pin_out), .o_pin_n(pin_n));
	// Pulldown run length, mode reloads and wait exits
	always @(posedge i_clock) begin
		oe_run <= o_rst_pin_oe ? oe_run + 1 : 0;
		if (!o_rst_pin_oe && oe_run != 0) last_oe <= oe_run;
		if (o_mode_load === 1'b1) ml <= ml + 1;
		if (o_lp_exit === 1'b1) lp <= lp + 1;
	end
	task automatic test_done;
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (n >= 50) begin
			errors++;
			test_done();
		end
	endtask
	task automatic wait_rel;
		c = 0;
		while (o_int_reset !== 1'b0) begin
			@(negedge i_clock);
			c++;
			if (c > 400) begin
				errors++;
				test_done();
			end
		end
		repeat (6) @(negedge i_clock);
	endtask
	// Cause flags read then cleared by writing ones
	task automatic cause(input string nm, input logic [5:0] exp);
		apb(1'b0, 16'h3FF4, 32'h00000000);
		check(nm, {26'h0, rd[5:0]}, {26'h0, exp});
		apb(1'b1, 16'h3FF4, 32'h0000003F);
	endtask
	task automatic t_regs;
		apb(1'b0, 16'h3FF0, 32'h00000000);
		check("svc_read", rd, 32'h0000005A);
		apb(1'b0, 16'h1000, 32'h00000000);
		check("unmapped_err", {31'h0, err}, 32'h00000001);
		check("unmapped_rd", rd, 32'h00000000);
	endtask
	task automatic t_fetch;
		logic [15:0] a[11] = '{16'h0000, 16'h003F, 16'h01C0, 16'h023F, 16'h02C0, 16'h17FF,
			16'h0040, 16'h01BF, 16'h0240, 16'h02BF, 16'h1800};
		for (int k = 0; k < 11; k++) begin
			@(posedge i_clock);
			i_fetch <= 1'b1;
			i_fetch_addr <= a[k];
			@(posedge i_clock);
			i_fetch <= 1'b0;
			@(negedge i_clock);
			check("fetch_reset", {31'h0, o_int_reset}, {31'h0, k < 6});
			wait_rel();
			if (k < 6) check("fetch_oe_len", {31'h0, last_oe inside {3, 4}}, 32'h1);
		end
		cause("fetch_cause", 6'h10);
	endtask
	task automatic t_src(input int kind);
		int m;
		m = ml;
		@(posedge i_clock);
		if (kind == 0) i_stop_exec <= 1'b1;
		else if (kind == 1) ext_low <= 1'b1;
		else i_low_supply <= 1'b1;
		@(posedge i_clock);
		i_stop_exec <= 1'b0;
		@(negedge i_clock);
		// An event reset is short, so it is looked at at once
		if (kind != 0) repeat (9) @(posedge i_clock);
		check("src_reset", {31'h0, o_int_reset}, 32'h1);
		if (kind == 0) check("no_stop", {31'h0, o_osc_stop}, 32'h0);
		if (kind != 0) begin
			ext_low <= 1'b0;
			i_low_supply <= 1'b0;
		end
		@(negedge i_clock);
		wait_rel();
		if (kind == 2) check("low_hold", {31'h0, c >= POR}, 32'h1);
		else check("pin_oe_len", {31'h0, last_oe inside {3, 4}}, 32'h1);
		check("mode_load", ml - m, kind == 1);
		cause("src_cause", kind == 0 ? 6'h20 : kind == 1 ? 6'h01 : 6'h08);
	endtask
	task automatic t_wdog;
		int m;
		m = ml;
		c = 0;
		// Services at half the period span several periods in all
		repeat (6) begin
			apb(1'b1, 16'h3FF0, 32'h00000000);
			repeat (WDOG / 2) begin
				@(posedge i_clock);
				c += o_int_reset;
			end
		end
		check("serviced", c, 0);
		apb(1'b1, 16'h3FF0, 32'h00000001);
		i_wait_mode <= 1'b1;
		c = 0;
		while (o_int_reset !== 1'b1 && c < 2 * WDOG) begin
			@(negedge i_clock);
			c++;
		end
		check("wdog_reset", {31'h0, o_int_reset}, 32'h1);
		check("one_no_service", {31'h0, c < WDOG - 8}, 32'h1);
		wait_rel();
		@(posedge i_clock);
		i_wait_mode <= 1'b0;
		check("wait_exit", {31'h0, lp > 0}, 32'h1);
		check("wdog_mode", ml - m, 1);
		cause("wdog_cause", 6'h04);
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		i_arst_n <= 1'b1;
		repeat (5) @(negedge i_clock);
		check("por_wait_osc", {31'h0, o_int_reset}, 32'h1);
		@(posedge i_clock);
		i_osc_active <= 1'b1;
		wait_rel();
		check("por_len", {31'h0, c >= POR}, 32'h1);
		check("clk_run", {31'h0, o_clk_run}, 32'h1);
		cause("por_cause", 6'h02);
		t_regs();
		t_fetch();
		for (int k = 0; k < 3; k++) t_src(k);
		t_wdog();
		test_done();
	end
endmodule // rsc_top_tb
bind rsc_top rsc_checker #(.USER_VEC(USER_VEC)) i_rsc_checker (.i_clock(i_clock),
	.i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .i_rst_pin_n(i_rst_pin_n),
	.o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe), .i_low_supply(i_low_supply),
	.i_fetch(i_fetch), .i_fetch_addr(i_fetch_addr), .i_stop_exec(i_stop_exec),
	.i_wait_mode(i_wait_mode), .o_int_reset(o_int_reset), .o_lp_exit(o_lp_exit),
	.o_osc_stop(o_osc_stop), .o_clk_run(o_clk_run));
`default_nettype wire
